/* core/encoder_position_counter.sv */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module encoder_position_counter
  import qei_pkg::*;
(
  // Clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  // Encoder pins
  input wire logic PHASE_A_IN_I,
  input wire logic PHASE_B_IN_I,
  input wire logic INDEX_IN_I,
  // Status outputs
  output logic DIRECTION_STATE_O,
  output logic ENCODER_IRQ_O,
  // AXI4-Lite write address and data
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import qei_pkg::*;

  decode_if dif();

  logic [7:0] awaddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_fire;
  logic wr_hit;
  logic wr_ctrl;
  logic wr_filt;
  logic wr_pos;
  logic wr_lim;
  logic wr_irq;
  logic [15:0] position_count;
  logic [15:0] count_limit;
  logic [15:0] pos_wdata;
  logic [15:0] next_count;
  logic [2:0] decoder_mode_select;
  logic index_reset_enable;
  logic count_error_flag;
  logic [1:0] index_state_match;
  logic count_error_irq_mask;
  logic encoder_irq_flag;
  logic active;
  logic limit_mode;
  logic idx_mode;
  logic cnt_en;
  logic up;
  logic roll_evt;
  logic idx_ok;
  logic idx_reset;
  logic index_evt;
  logic err_hit;
  logic index_prev;
  logic has_ref;
  logic [1:0] ref_from;
  logic [1:0] ref_to;
  logic [31:0] rd_mux;
  logic rd_hit;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
    input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  quad_decoder u_dec (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .phase_a_in(PHASE_A_IN_I),
    .phase_b_in(PHASE_B_IN_I),
    .index_in(INDEX_IN_I),
    .dec(dif.dec)
  );

  // Mode decode
  assign active = decoder_mode_select[2];
  assign limit_mode = active && decoder_mode_select[0]; // [RULE4]
  assign idx_mode = active && !decoder_mode_select[0];
  assign dif.x2_mode = active && !decoder_mode_select[1]; // [RULE16]
  assign cnt_en = active && dif.count_pulse;
  assign up = dif.count_up;

  // Write channel: address and data taken in either order
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
      awaddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
    end else if (CE_I) begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        S_AXI_AWREADY_O <= 1'b0;
        awaddr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        S_AXI_WREADY_O <= 1'b0;
        wdata <= S_AXI_WDATA_I;
        wstrb <= S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Write decode
  assign wr_fire = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
  assign wr_ctrl = wr_fire && awaddr == OFS_CONTROL;
  assign wr_filt = wr_fire && awaddr == OFS_FILTER;
  assign wr_pos = wr_fire && awaddr == OFS_POSITION;
  assign wr_lim = wr_fire && awaddr == OFS_LIMIT;
  assign wr_irq = wr_fire && awaddr == OFS_IRQ;
  assign wr_hit = wr_ctrl || wr_filt || wr_pos || wr_lim || wr_irq;
  assign pos_wdata = merge16(position_count, wdata, wstrb);

  // Control, filter and limit configuration fields
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      decoder_mode_select <= MODE_RST;
      index_reset_enable <= 1'b0;
      index_state_match <= MATCH_RST;
      count_error_irq_mask <= 1'b0;
      count_limit <= LIMIT_RST;
    end else if (CE_I) begin
      if (wr_ctrl && wstrb[1]) begin
        decoder_mode_select <= wdata[CTL_MODE_LSB +: 3];
      end
      if (wr_ctrl && wstrb[0]) begin
        index_reset_enable <= wdata[CTL_RST_EN_BIT]; // [RULE14]
      end
      if (wr_filt && wstrb[1]) begin
        index_state_match <= wdata[FLT_MATCH_LSB +: 2]; // [RULE9]
        count_error_irq_mask <= wdata[FLT_MASK_BIT]; // [RULE12]
      end
      if (wr_lim) begin
        count_limit <= merge16(count_limit, wdata, wstrb);
      end
    end
  end

  // Index qualification and transition match
  assign idx_ok = dif.index_level &&
    (dif.state_cur == index_state_match || dif.state_prev == index_state_match); // [RULE9]
  assign idx_reset = idx_mode && index_reset_enable && cnt_en && idx_ok &&
    (!has_ref || (dif.state_prev == ref_from && dif.state_cur == ref_to) ||
     (dif.state_prev == ref_to && dif.state_cur == ref_from)); // [RULE8]
  assign index_evt = idx_mode && dif.index_level && !index_prev; // [RULE15]

  // Latch the transition of the first recognised index
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      has_ref <= 1'b0;
      ref_from <= 2'h0;
      ref_to <= 2'h0;
      index_prev <= 1'b0;
    end else if (CE_I) begin
      index_prev <= dif.index_level;
      if (!idx_mode) begin
        has_ref <= 1'b0;
      end else if (idx_reset && !has_ref) begin
        has_ref <= 1'b1; // [RULE8]
        ref_from <= dif.state_prev;
        ref_to <= dif.state_cur;
      end
    end
  end

  // Next count from pulses, limits and index
  always_comb begin
    next_count = position_count;
    roll_evt = 1'b0;
    if (cnt_en) begin
      if (idx_reset) begin
        next_count = up ? 16'h0000 : count_limit; // [RULE7]
      end else if (limit_mode || !index_reset_enable) begin
        if (up && position_count == count_limit) begin
          next_count = 16'h0000; // [RULE5]
          roll_evt = limit_mode;
        end else if (!up && position_count == 16'h0000) begin
          next_count = count_limit; // [RULE6]
          roll_evt = limit_mode;
        end else begin
          next_count = up ? position_count + 16'h0001 : position_count - 16'h0001;
        end
      end else begin
        next_count = up ? position_count + 16'h0001 : position_count - 16'h0001; // [RULE1]
      end
    end
  end

  // Boundary error check in index mode
  assign err_hit = idx_mode && cnt_en && !wr_pos && !idx_reset &&
    (up ? next_count == count_limit + 16'h0001 : next_count == 16'hffff); // [RULE11]

  // Position counter, software load first
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      position_count <= POSITION_RST;
    end else if (CE_I) begin
      if (wr_pos) begin
        position_count <= pos_wdata; // [RULE2] [RULE18]
      end else begin
        position_count <= next_count; // [RULE1] [RULE3]
      end
    end
  end

  // Count error flag: hardware set wins over software clear
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      count_error_flag <= 1'b0;
    end else if (CE_I) begin
      if (err_hit) begin
        count_error_flag <= 1'b1; // [RULE11]
      end else if (wr_ctrl && wstrb[1] && !wdata[CTL_ERR_BIT]) begin
        count_error_flag <= 1'b0; // [RULE13]
      end
    end
  end

  // Interrupt flag, sticky until written with one
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      encoder_irq_flag <= 1'b0;
    end else if (CE_I) begin
      if ((roll_evt && !wr_pos) || index_evt ||
          (err_hit && !count_error_irq_mask && !count_error_flag)) begin
        encoder_irq_flag <= 1'b1; // [RULE12] [RULE13] [RULE17]
      end else if (wr_irq && wstrb[0] && wdata[0]) begin
        encoder_irq_flag <= 1'b0; // [RULE17]
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      ENCODER_IRQ_O <= 1'b0;
      DIRECTION_STATE_O <= 1'b0;
    end else if (CE_I) begin
      ENCODER_IRQ_O <= encoder_irq_flag;
      DIRECTION_STATE_O <= dif.direction_state;
    end
  end

  // Read data select
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (S_AXI_ARADDR_I)
      OFS_CONTROL: begin
        rd_mux[CTL_ERR_BIT] = count_error_flag;
        rd_mux[CTL_INDEX_BIT] = dif.index_level; // [RULE10]
        rd_mux[CTL_DIR_BIT] = dif.direction_state;
        rd_mux[CTL_MODE_LSB +: 3] = decoder_mode_select;
        rd_mux[CTL_RST_EN_BIT] = index_reset_enable;
      end
      OFS_FILTER: begin
        rd_mux[FLT_MATCH_LSB +: 2] = index_state_match;
        rd_mux[FLT_MASK_BIT] = count_error_irq_mask;
      end
      OFS_POSITION: rd_mux[15:0] = position_count; // [RULE2]
      OFS_LIMIT: rd_mux[15:0] = count_limit;
      OFS_IRQ: rd_mux[0] = encoder_irq_flag;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else if (CE_I) begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_mux;
        S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

  // Checks on counter behaviour
  chk_sw_write_wins: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE18]
    (CE_I && wr_pos) |=> position_count == $past(pos_wdata))
    else $error("software load of count lost");
  chk_mode_keeps_count: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE3]
    (CE_I && wr_ctrl && !dif.count_pulse) |=> $stable(position_count))
    else $error("mode change altered count");
  chk_rollover_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE5]
    (CE_I && limit_mode && cnt_en && up && position_count == count_limit && !wr_pos)
    |=> position_count == 16'h0000 && encoder_irq_flag)
    else $error("rollover did not reach zero with event");
  chk_underflow_limit: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE6]
    (CE_I && limit_mode && cnt_en && !up && position_count == 16'h0000 && !wr_pos)
    |=> position_count == $past(count_limit) && encoder_irq_flag)
    else $error("underflow did not load limit with event");
  chk_index_reset_dir: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE7]
    (CE_I && idx_reset && !wr_pos)
    |=> position_count == ($past(up) ? 16'h0000 : $past(count_limit)))
    else $error("index reset value wrong for direction");
  chk_count_step_one: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE1]
    (CE_I && idx_mode && index_reset_enable && cnt_en && !idx_reset && !wr_pos)
    |=> position_count == $past(position_count) + ($past(up) ? 16'h0001 : 16'hffff))
    else $error("count did not step by one");
  chk_index_status: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE10]
    (CE_I && S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == OFS_CONTROL)
    |=> S_AXI_RDATA_O[CTL_INDEX_BIT] == $past(dif.index_level))
    else $error("index status bit mismatch");
  chk_error_flag_set: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE11]
    (CE_I && err_hit) |=> count_error_flag ##1 (count_error_flag || !$past(CE_I) || wr_ctrl
    || $past(wr_ctrl)))
    else $error("count error not flagged");
  chk_error_irq_masked: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE12]
    (CE_I && !encoder_irq_flag && err_hit && count_error_irq_mask && !index_evt
    && !roll_evt) |=> !encoder_irq_flag)
    else $error("masked count error raised interrupt");
  chk_irq_sticky: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) // [RULE17]
    (CE_I && encoder_irq_flag && !wr_irq) |=> encoder_irq_flag)
    else $error("interrupt flag dropped without clear");
endmodule

/* core/qei_pkg.sv */
// Operation
// RULE1 - Sixteen-bit count steps on each decoder pulse
// RULE2 - Software reads count and loads start value
// RULE3 - Changing decoder mode keeps the count
// RULE4 - Mode 1x1 resets only at limit/zero
// RULE5 - Up at limit wraps to zero, event
// RULE6 - Down at zero loads limit, event
// RULE7 - Mode 1x0 index resets count by direction
// RULE8 - Index reset on latched, mirrored quadrature transition
// RULE9 - Match field selects phase levels for index
// RULE10 - Status bit twelve shows filtered index level
// RULE11 - Index mode flags limit+1 or 0xffff error
// RULE12 - Error raises interrupt unless mask bit set
// RULE13 - Counting continues; one error interrupt until cleared
// RULE14 - Reset enable: index reset, else wrap
// RULE15 - Index mode raises event per index pulse
// RULE16 - Mode 11x counts x4, 10x counts x2
// RULE17 - Interrupt flag stays set until software clears
// RULE18 - Software count write beats counting that cycle
package qei_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FILTER = 8'h04;
  localparam logic [7:0] OFS_POSITION = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_IRQ = 8'h10;
  // Control register fields
  localparam int CTL_ERR_BIT = 15;
  localparam int CTL_INDEX_BIT = 12;
  localparam int CTL_DIR_BIT = 11;
  localparam int CTL_MODE_LSB = 8;
  localparam int CTL_RST_EN_BIT = 2;
  // Filter register fields
  localparam int FLT_MATCH_LSB = 9;
  localparam int FLT_MASK_BIT = 8;
  // Values after reset
  localparam logic [15:0] POSITION_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] MATCH_RST = 2'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/decode_if.sv */
`timescale 1ns/1ps
interface decode_if;
  logic x2_mode;
  logic count_pulse;
  logic count_up;
  logic direction_state;
  logic index_level;
  logic [1:0] state_prev;
  logic [1:0] state_cur;
  modport dec (input x2_mode, output count_pulse, count_up, direction_state,
    index_level, state_prev, state_cur);
  modport core (output x2_mode, input count_pulse, count_up, direction_state,
    index_level, state_prev, state_cur);
endinterface

/* core/quad_decoder.sv */
`timescale 1ns/1ps
module quad_decoder
  import qei_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Encoder pins
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic index_in,
  // Decoded events
  decode_if.dec dec
);
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] prev_ab;
  logic a_chg;
  logic b_chg;
  logic valid_step;

  // Two-stage synchronisers for the three pins
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev_ab <= 2'h0;
    end else if (ce_i) begin
      sync1 <= {index_in, phase_a_in, phase_b_in};
      sync2 <= sync1;
      prev_ab <= sync2[1:0];
    end
  end

  // Edge and lead/lag decode
  assign a_chg = sync2[1] ^ prev_ab[1];
  assign b_chg = sync2[0] ^ prev_ab[0];
  assign valid_step = a_chg ^ b_chg;

  // Count pulse, direction and state tracking
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dec.count_pulse <= 1'b0;
      dec.count_up <= 1'b0;
      dec.direction_state <= 1'b0;
      dec.index_level <= 1'b0;
      dec.state_prev <= 2'h0;
      dec.state_cur <= 2'h0;
    end else if (ce_i) begin
      dec.count_pulse <= valid_step && (a_chg || !dec.x2_mode); // [RULE16]
      dec.count_up <= sync2[1] ^ prev_ab[0];
      if (valid_step) begin
        dec.direction_state <= sync2[1] ^ prev_ab[0];
      end
      dec.index_level <= sync2[2];
      dec.state_prev <= prev_ab;
      dec.state_cur <= sync2[1:0];
    end
  end
endmodule

/* sim/quad_encoder_model.sv */
`timescale 1ns/1ps
module quad_encoder_model (
  // Clock
  input wire logic clk_i,
  // Encoder outputs
  output logic phase_a_o,
  output logic phase_b_o,
  output logic index_o
);
  int unsigned pos_q = 0;

  // Idle levels before the first step
  initial begin
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
    index_o = 1'b0;
  end

  // One quadrature step, A leads B going forward, one phase per step
  task automatic step(input bit fwd, input int hold);
    @(posedge clk_i);
    pos_q = fwd ? (pos_q + 1) % 4 : (pos_q + 3) % 4;
    phase_a_o <= (pos_q == 1 || pos_q == 2);
    phase_b_o <= (pos_q >= 2);
    repeat (hold) @(posedge clk_i);
  endtask

  // Index level, held long enough to pass the synchroniser
  task automatic set_index(input bit lvl);
    @(posedge clk_i);
    index_o <= lvl;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

/* sim/test_encoder_position_counter.sv */
`timescale 1ns/1ps
module test_encoder_position_counter;
  import qei_pkg::*;
  // Design ports
  logic SYS_CLK_I = 0, RST_B_I = 0, CE_I = 1;
  logic PHASE_A_IN_I, PHASE_B_IN_I, INDEX_IN_I, DIRECTION_STATE_O, ENCODER_IRQ_O;
  logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
  logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic [31:0] S_AXI_WDATA_I = 0, S_AXI_RDATA_O, rdat;
  logic [3:0] S_AXI_WSTRB_I = 0;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, resp;
  // Reference model state
  int num_errors = 0, compares = 0, exp_pos = 0, exp_lim = 16'hffff;
  bit x2 = 0, plain = 0;

  // Clock
  always #5 SYS_CLK_I = ~SYS_CLK_I;

  encoder_position_counter encoder_position_counter_inst (.SYS_CLK_I, .RST_B_I, .CE_I,
    .PHASE_A_IN_I, .PHASE_B_IN_I, .INDEX_IN_I, .DIRECTION_STATE_O, .ENCODER_IRQ_O,
    .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
    .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
    .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
    .S_AXI_RVALID_O, .S_AXI_RREADY_I);
  quad_encoder_model quad_encoder_model_inst (.clk_i(SYS_CLK_I), .phase_a_o(PHASE_A_IN_I),
    .phase_b_o(PHASE_B_IN_I), .index_o(INDEX_IN_I));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge SYS_CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WDATA_I <= d;
    S_AXI_WSTRB_I <= s;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge SYS_CLK_I);
      if (!ad && S_AXI_AWREADY_O === 1'b1) begin
        ad = 1;
        S_AXI_AWVALID_I <= 1'b0;
      end
      if (!wd && S_AXI_WREADY_O === 1'b1) begin
        wd = 1;
        S_AXI_WVALID_I <= 1'b0;
      end
    end
    do @(posedge SYS_CLK_I); while (S_AXI_BVALID_O !== 1'b1);
    r = S_AXI_BRESP_O;
    S_AXI_BREADY_I <= 1'b0;
  endtask

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge SYS_CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do @(posedge SYS_CLK_I); while (S_AXI_ARREADY_O !== 1'b1);
    S_AXI_ARVALID_I <= 1'b0;
    do @(posedge SYS_CLK_I); while (S_AXI_RVALID_O !== 1'b1);
    d = S_AXI_RDATA_O;
    r = S_AXI_RRESP_O;
    S_AXI_RREADY_I <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, rdat, resp);
    chk(nm, e, rdat);
    chk({nm, " resp"}, 32'(RESP_OKAY), 32'(resp));
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wr(a, d, s, resp);
    chk("write resp", 32'(RESP_OKAY), 32'(resp));
  endtask

  // Flag, pin, then clear
  task automatic irq_check(input logic e);
    rchk(OFS_IRQ, 32'(e), "irq flag");
    @(negedge SYS_CLK_I);
    chk("irq pin", 32'(e), 32'(ENCODER_IRQ_O));
    wchk(OFS_IRQ, 32'h1, 4'h1);
  endtask

  function automatic logic [31:0] ctl(input bit err, ix, dir, input logic [2:0] m,
    input bit en);
    return {16'h0, err, 2'b0, ix, dir, m, 5'b0, en, 2'b0};
  endfunction

  // Encoder step plus reference count, x2 counts only A edges
  task automatic mstep(input bit fwd);
    int hold;
    bit cnt;
    hold = $urandom_range(5, 12);
    cnt = !x2 || ((quad_encoder_model_inst.pos_q % 2 == 0) == fwd);
    quad_encoder_model_inst.step(fwd, hold);
    if (cnt && plain)
      exp_pos = fwd ? (exp_pos + 1) % 65536 : (exp_pos + 65535) % 65536;
    else if (cnt && fwd)
      exp_pos = (exp_pos == exp_lim) ? 0 : exp_pos + 1;
    else if (cnt)
      exp_pos = (exp_pos == 0) ? exp_lim : exp_pos - 1;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge SYS_CLK_I);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hce1c));
    repeat (8) @(posedge SYS_CLK_I);
    RST_B_I <= 1'b1;
    rchk(OFS_CONTROL, 32'h0, "control");
    rchk(OFS_FILTER, 32'h0, "filter");
    rchk(OFS_POSITION, 32'(POSITION_RST), "position");
    rchk(OFS_LIMIT, 32'(LIMIT_RST), "limit");
    rchk(OFS_IRQ, 32'h0, "irq flag");
    rd(8'h14, rdat, resp);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
    wr(8'h14, 32'hffff, 4'hf, resp);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
    // Limit mode from a random start
    exp_lim = 5;
    exp_pos = $urandom_range(0, 5);
    wchk(OFS_LIMIT, 32'(exp_lim), 4'h3);
    wchk(OFS_POSITION, 32'(exp_pos), 4'h3);
    wchk(OFS_CONTROL, ctl(0, 0, 0, 3'b111, 0), 4'h3);
    rchk(OFS_POSITION, 32'(exp_pos), "position kept");
    repeat (8) mstep(1);
    rchk(OFS_POSITION, 32'(exp_pos), "position up");
    irq_check(1);
    repeat (8) mstep(0);
    rchk(OFS_POSITION, 32'(exp_pos), "position down");
    rchk(OFS_CONTROL, ctl(0, 0, 0, 3'b111, 0), "control down");
    irq_check(1);
    // Half resolution keeps the count
    x2 = 1;
    wchk(OFS_CONTROL, ctl(0, 0, 0, 3'b101, 0), 4'h3);
    rchk(OFS_POSITION, 32'(exp_pos), "position after mode change");
    repeat (4) mstep(1);
    rchk(OFS_POSITION, 32'(exp_pos), "position x2");
    @(negedge SYS_CLK_I);
    chk("direction pin", 32'h1, 32'(DIRECTION_STATE_O));
    // Clock enable low freezes the decoder; B-only steps never count in x2
    @(posedge SYS_CLK_I);
    CE_I <= 1'b0;
    mstep(0);
    @(negedge SYS_CLK_I);
    chk("frozen direction", 32'h1, 32'(DIRECTION_STATE_O));
    @(posedge SYS_CLK_I);
    CE_I <= 1'b1;
    mstep(1);
    rchk(OFS_POSITION, 32'(exp_pos), "position after freeze");
    wchk(OFS_IRQ, 32'h1, 4'h1);
    // Index reset on the latched transition and its mirror
    x2 = 0;
    plain = 1;
    wchk(OFS_FILTER, 32'h0600, 4'h2);
    wchk(OFS_CONTROL, ctl(0, 0, 0, 3'b110, 1), 4'h3);
    wchk(OFS_POSITION, 32'h0, 4'h3);
    exp_pos = 0;
    while (quad_encoder_model_inst.pos_q != 1) mstep(1);
    quad_encoder_model_inst.set_index(1);
    rchk(OFS_CONTROL, ctl(0, 1, 1, 3'b110, 1), "control index");
    mstep(1);
    exp_pos = 0;
    rchk(OFS_POSITION, 32'(exp_pos), "index reset forward");
    mstep(0);
    exp_pos = exp_lim;
    rchk(OFS_POSITION, 32'(exp_pos), "index reset reverse");
    mstep(1);
    exp_pos = 0;
    mstep(1);
    rchk(OFS_POSITION, 32'(exp_pos), "other transition");
    quad_encoder_model_inst.set_index(0);
    irq_check(1);
    // Count error, one interrupt until cleared, then masked
    wchk(OFS_POSITION, 32'h0, 4'h3);
    exp_pos = 0;
    mstep(0);
    rchk(OFS_POSITION, 32'(exp_pos), "position below zero");
    rchk(OFS_CONTROL, ctl(1, 0, 0, 3'b110, 1), "error flag");
    irq_check(1);
    wchk(OFS_POSITION, 32'(exp_lim), 4'h3);
    exp_pos = exp_lim;
    mstep(1);
    rchk(OFS_POSITION, 32'(exp_pos), "position above limit");
    irq_check(0);
    wchk(OFS_CONTROL, ctl(0, 0, 0, 3'b110, 1), 4'h3);
    rchk(OFS_CONTROL, ctl(0, 0, 1, 3'b110, 1), "error cleared");
    wchk(OFS_FILTER, 32'h0700, 4'h2);
    wchk(OFS_POSITION, 32'h0, 4'h3);
    exp_pos = 0;
    mstep(0);
    rchk(OFS_CONTROL, ctl(1, 0, 0, 3'b110, 1), "masked error flag");
    irq_check(0);
    // Index without reset enable wraps and still interrupts
    // Half resolution index mode
    plain = 0;
    x2 = 1;
    wchk(OFS_CONTROL, ctl(0, 0, 0, 3'b100, 0), 4'h3);
    wchk(OFS_POSITION, 32'(exp_lim), 4'h3);
    exp_pos = exp_lim;
    quad_encoder_model_inst.set_index(1);
    repeat (2) mstep(1);
    rchk(OFS_POSITION, 32'(exp_pos), "wrap without reset");
    quad_encoder_model_inst.set_index(0);
    irq_check(1);
    end_sim();
  end
endmodule
